// ===== core/epg_ctrl.sv
// enable, undervoltage gating, output sequencing and global power-good for six regulator channels
// assumes comparator levels are asynchronous, a classic wishbone master, one 200 MHz clock
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module epg_ctrl
  import epg_pkg::*;
#(
  parameter int unsigned SEQ_CYC  = SEQ_CYCLES,
  parameter int unsigned GLITCH_CYC = DEGLITCH_CYCLES
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // wishbone classic slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [31:0]    wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  output logic                wb_err_o,
  // pins and comparators
  input  wire logic           enable_i,
  input  wire logic           supply_above_upper_i,
  input  wire logic           supply_below_lower_i,
  input  wire logic           thermal_fault_i,
  input  wire logic [NCH-1:0] channel_good_i,
  output logic      [NCH-1:0] channel_on_o,
  output logic      [NCH-1:0] discharge_en_o,
  output logic                boost_disconnect_close_o,
  output logic                global_power_good_out_o,
  output logic                global_power_good_out_oe_o
);

  typedef struct packed {
    epg_state_e     state;
    logic [2:0]     step;
    epg_cnt_t       seq_cnt;
    epg_cnt_t       glitch_cnt;
    logic           supply_ok;
    logic           pg;
    logic [NCH-1:0] on;
    logic [NCH-1:0] dis;
    logic           disc_close;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0] dsel;
    logic [NCH-1:0] mask;
    logic           ack;
    logic           err;
    logic [31:0]    rdat;
  } epg_ctrl_s;

  epg_ctrl_s s_q;
  epg_ctrl_s s_d;

  epg_sense_if sns ();

  logic           en_s;
  logic           up_s;
  logic           lo_s;
  logic           hot_s;
  logic [NCH-1:0] good_s;
  logic           run_ok;
  logic           fault_now;
  logic           req;
  logic           ctrl_hit;
  logic           stat_hit;
  logic [31:0]    ctrl_word;
  logic [31:0]    stat_word;
  logic [31:0]    wr_word;
  logic [31:0]    rd_word;
  logic [NCH-1:0] ch_fault;
  logic [NCH-1:0] ch_start;
  logic           step_due;
  logic           last_step;
  logic           glitch_due;
  logic           take;
  logic           wr_hit;

  assign sns.raw = {channel_good_i, thermal_fault_i, supply_below_lower_i,
                    supply_above_upper_i, enable_i};

  epg_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sns   (sns.sync_end)
  );

  // only the clean copies are used below
  assign en_s   = sns.sync[SNS_EN];
  assign up_s   = sns.sync[SNS_UP];
  assign lo_s   = sns.sync[SNS_LO];
  assign hot_s  = sns.sync[SNS_HOT];
  assign good_s = sns.sync[SNS_GOOD +: NCH];

  assign req      = wb_cyc_i & wb_stb_i;
  assign ctrl_hit = (wb_adr_i == CTRL_OFS);
  assign stat_hit = (wb_adr_i == STAT_OFS);
  // a new request is taken only with no answer outstanding, so ack stays a one-cycle pulse
  assign take     = req & ~s_q.ack & ~s_q.err;
  // only the control register is writable; status writes fall through silently
  assign wr_hit   = req & s_q.ack & wb_we_i & ctrl_hit;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_CHEN_POS +: NCH] = s_q.ch_en;
    ctrl_word[CTRL_DSEL_POS +: NCH] = s_q.dsel;
    ctrl_word[CTRL_MASK_POS +: NCH] = s_q.mask;
    stat_word = '0;
    stat_word[STAT_ON_POS +: NCH]   = s_q.on;
    stat_word[STAT_GOOD_POS +: NCH] = good_s;
    stat_word[STAT_ST_POS +: 3]     = s_q.state;
    stat_word[STAT_PG_POS]          = s_q.pg;
    stat_word[STAT_EN_POS]          = en_s;
    stat_word[STAT_UV_POS]          = s_q.supply_ok;
  end

  // byte lanes merge into the current control word
  always_comb begin
    wr_word = ctrl_word;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        wr_word[8*b +: 8] = wb_dat_i[8*b +: 8];
      end
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ctrl_hit) begin
      rd_word = ctrl_word;
    end else if (stat_hit) begin
      rd_word = stat_word;
    end
  end

  // sequencing and deglitch strobes, named so the state update below stays readable
  assign step_due   = (s_q.state == ST_SEQ) && (s_q.seq_cnt == epg_cnt_t'(SEQ_CYC - 1));
  assign last_step  = (s_q.step == 3'(NCH - 1));
  assign glitch_due = (s_q.glitch_cnt == epg_cnt_t'(GLITCH_CYC - 1));

  // one channel per step, only the one whose turn it is and only if enabled
  // a set mask bit hides that channel's good flag from power-good
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign ch_start[c] = step_due & (s_q.step == 3'(c)) & s_q.ch_en[c];
    assign ch_fault[c] = ~good_s[c] & ~s_q.mask[c];
  end

  // unmasked channel faults or a hot die count as a fault
  assign fault_now = hot_s | (|ch_fault);
  assign run_ok    = en_s & s_q.supply_ok;

  always_comb begin
    s_d = s_q;

    // hysteresis: set above upper, clear only below lower
    if (up_s) begin
      s_d.supply_ok = 1'b1;
    end else if (lo_s) begin
      s_d.supply_ok = 1'b0;
    end

    unique case (s_q.state)
      ST_OFF: begin
        s_d.seq_cnt = '0;
        s_d.step    = '0;
        if (run_ok) begin
          // enable high with supply good starts the sequence
          s_d.state      = ST_SEQ;
          s_d.disc_close = 1'b1;
        end
      end
      ST_SEQ: begin
        if (step_due) begin
          // one channel per sequencing delay
          s_d.seq_cnt = '0;
          s_d.on      = s_q.on | ch_start;
          s_d.step    = s_q.step + 3'd1;
          if (last_step) begin
            s_d.state = ST_ON;
          end
        end else begin
          s_d.seq_cnt = s_q.seq_cnt + epg_cnt_t'(1);
        end
      end
      ST_ON: begin
        s_d.seq_cnt = '0;
      end
    endcase

    // a channel disabled by software while running drops out at once
    if (s_q.state != ST_OFF) begin
      s_d.on = s_d.on & s_q.ch_en;
    end

    // losing enable or supply shuts everything down at once
    if (!run_ok) begin
      s_d.state      = ST_OFF;
      s_d.on         = '0;
      s_d.disc_close = 1'b0;
      s_d.step       = '0;
      s_d.seq_cnt    = '0;
    end

    // discharge only channels that are off and selected
    s_d.dis = ~s_d.on & s_q.dsel;

    // power-good rises at once, falls at once on shutdown, otherwise only after a lasting fault
    if (s_q.state != ST_ON || !run_ok) begin
      s_d.pg         = 1'b0;
      s_d.glitch_cnt = '0;
    end else if (!fault_now) begin
      s_d.pg         = 1'b1;
      s_d.glitch_cnt = '0;
    end else if (s_q.pg) begin
      if (glitch_due) begin
        s_d.pg         = 1'b0;
        s_d.glitch_cnt = '0;
      end else begin
        s_d.glitch_cnt = s_q.glitch_cnt + epg_cnt_t'(1);
      end
    end

    // wishbone: answer one cycle after the request, drop the cycle after
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    if (take) begin
      // no programming or reads while enable is low; refused with err
      if (en_s) begin
        s_d.ack  = 1'b1;
        s_d.rdat = rd_word;
      end else begin
        s_d.err  = 1'b1;
        s_d.rdat = 32'h0000_0000;
      end
    end
    // the write lands on the edge where the master sees ack
    if (wr_hit) begin
      s_d.ch_en = wr_word[CTRL_CHEN_POS +: NCH];
      s_d.dsel  = wr_word[CTRL_DSEL_POS +: NCH];
      s_d.mask  = wr_word[CTRL_MASK_POS +: NCH];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.state      <= ST_OFF;
      s_q.step       <= '0;
      s_q.seq_cnt    <= '0;
      s_q.glitch_cnt <= '0;
      s_q.supply_ok  <= 1'b0;
      s_q.pg         <= 1'b0;
      s_q.on         <= '0;
      s_q.dis        <= '0;
      s_q.disc_close <= 1'b0;
      s_q.ch_en      <= CHEN_RST;
      s_q.dsel       <= DSEL_RST;
      s_q.mask       <= MASK_RST;
      s_q.ack        <= 1'b0;
      s_q.err        <= 1'b0;
      s_q.rdat       <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o                   = s_q.rdat;
  assign wb_ack_o                   = s_q.ack;
  assign wb_err_o                   = s_q.err;
  assign channel_on_o               = s_q.on;
  assign discharge_en_o             = s_q.dis;
  assign boost_disconnect_close_o   = s_q.disc_close;
  // open drain: drive low when not good, release otherwise
  assign global_power_good_out_o    = 1'b0;
  assign global_power_good_out_oe_o = ~s_q.pg;

endmodule

// ===== core/epg_pkg.sv
// constants, types and register layout for the enable and power-good controller
// assumes a 200 MHz system clock and a 32-bit classic wishbone register bus
package epg_pkg;

  localparam int unsigned NCH           = 6;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned SEQ_DELAY_MS  = 1;
  localparam int unsigned DEGLITCH_US   = 50;
  // sequencing delay is nominal, so round down; deglitch is a least time, so round up
  localparam int unsigned SEQ_CYCLES    = SEQ_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned DEGLITCH_CYCLES = (DEGLITCH_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned CNT_W         = 18;

  // sense vector layout shared by the top and the synchroniser
  localparam int unsigned SNS_EN        = 0;
  localparam int unsigned SNS_UP        = 1;
  localparam int unsigned SNS_LO        = 2;
  localparam int unsigned SNS_HOT       = 3;
  localparam int unsigned SNS_GOOD      = 4;
  localparam int unsigned SNS_W         = SNS_GOOD + NCH;

  // register map
  localparam logic [31:0] CTRL_OFS      = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS      = 32'h0000_0004;
  localparam int unsigned CTRL_CHEN_POS = 0;
  localparam int unsigned CTRL_DSEL_POS = 8;
  localparam int unsigned CTRL_MASK_POS = 16;
  localparam int unsigned STAT_ON_POS   = 0;
  localparam int unsigned STAT_GOOD_POS = 8;
  localparam int unsigned STAT_ST_POS   = 16;
  localparam int unsigned STAT_PG_POS   = 24;
  localparam int unsigned STAT_EN_POS   = 25;
  localparam int unsigned STAT_UV_POS   = 26;
  localparam logic [5:0]  CHEN_RST      = 6'h3F;
  localparam logic [5:0]  DSEL_RST      = 6'h3F;
  localparam logic [5:0]  MASK_RST      = 6'h00;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_SEQ = 3'b010,
    ST_ON  = 3'b100
  } epg_state_e;

  typedef logic [CNT_W-1:0] epg_cnt_t;

endpackage

// ===== core/epg_sense_if.sv
// carries raw comparator and pin levels into the synchroniser and the clean copies back
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface epg_sense_if;
  import epg_pkg::*;
  logic [SNS_W-1:0] raw;
  logic [SNS_W-1:0] sync;
  modport ctrl (output raw, input sync);
  modport sync_end (input raw, output sync);
endinterface

// ===== core/epg_sync.sv
// two-flop synchroniser for every asynchronous level into the controller
// assumes raw levels may change at any time relative to clk_i
`timescale 1ns/1ps
module epg_sync
  import epg_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  epg_sense_if.sync_end sns
);

  typedef struct packed {
    logic [SNS_W-1:0] meta;
    logic [SNS_W-1:0] clean;
  } epg_sync_s;

  epg_sync_s s_q;
  epg_sync_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.meta  = sns.raw;
    // first stage feeds only the second stage
    s_d.clean = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sns.sync = s_q.clean;

endmodule

// ===== verif/epg_ctrl_chk.sv
// port-level assertions for the enable and power-good controller
// assumes one clock with synchronous active-high reset
`timescale 1ns/1ps
module epg_ctrl_chk
  import epg_pkg::*;
#(
  parameter int unsigned SEQ_CYC    = 20,
  parameter int unsigned GLITCH_CYC = 8
) (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic           wb_err_o,
  input wire logic           enable_i,
  input wire logic           thermal_fault_i,
  input wire logic [NCH-1:0] channel_on_o,
  input wire logic [NCH-1:0] discharge_en_o,
  input wire logic           boost_disconnect_close_o,
  input wire logic           global_power_good_out_o,
  input wire logic           global_power_good_out_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // length of the current thermal fault, in cycles
  logic [15:0] hot_q, hot_d;
  always_comb hot_d = thermal_fault_i ? hot_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_i) hot_q <= rst_i ? 16'h0000 : hot_d;

  a_answer_next: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o || wb_err_o)
    else $error("bus request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
    else $error("ack held too long");
  a_err_no_data: assert property (wb_err_o |-> wb_dat_o == 32'h0000_0000 && !wb_ack_o)
    else $error("refused access returned data");
  a_off_at_once: assert property (!enable_i [*5] |=> !(|channel_on_o) && !boost_disconnect_close_o)
    else $error("outputs still on with enable low");
  a_start_after_en: assert property ($rose(boost_disconnect_close_o) |-> $past(enable_i, 3))
    else $error("sequence started without enable");
  a_step_space: assert property ($rose(channel_on_o[1]) |->
    $past(channel_on_o[0], SEQ_CYC) && !$past(channel_on_o[0], SEQ_CYC + 1))
    else $error("sequencing step spacing wrong");
  a_pg_running: assert property (!global_power_good_out_oe_o |-> boost_disconnect_close_o)
    else $error("power good released while off");
  a_pg_open_drain: assert property (global_power_good_out_o == 1'b0)
    else $error("power good data not low");
  a_fault_drops: assert property (hot_q > GLITCH_CYC + 4 |-> global_power_good_out_oe_o)
    else $error("thermal fault did not pull power good");
  a_deglitch_hold: assert property ($rose(global_power_good_out_oe_o) && boost_disconnect_close_o |->
    !$past(global_power_good_out_oe_o, GLITCH_CYC))
    else $error("power good fell before deglitch time");
  a_discharge_off: assert property (!(|(discharge_en_o & channel_on_o)))
    else $error("discharge on a running channel");
  c_pg_up: cover property ($fell(global_power_good_out_oe_o));
  c_refused: cover property (wb_err_o);
  c_all_on: cover property (&channel_on_o);
endmodule

bind epg_ctrl epg_ctrl_chk #(.SEQ_CYC(SEQ_CYC), .GLITCH_CYC(GLITCH_CYC)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .enable_i, .thermal_fault_i, .channel_on_o, .discharge_en_o,
  .boost_disconnect_close_o, .global_power_good_out_o, .global_power_good_out_oe_o);

// ===== verif/epg_host.sv
// host model: drives the enable pin and reads the open-drain power-good wire
// assumes a pull-up on power good and the controller clock
`timescale 1ns/1ps
module epg_host (
  input  wire logic clk_i,
  input  wire logic en_req_i,
  input  wire logic pg_oe_i,
  output logic      enable_o,
  output logic      pg_level_o
);
  initial enable_o = 1'b0;
  // enable moves only just after an edge
  always @(posedge clk_i) enable_o <= en_req_i;
  assign pg_level_o = pg_oe_i ? 1'b0 : 1'b1;
endmodule

// ===== verif/enable_and_power_good_control_test.sv
// self-checking bench for the enable and power-good controller
// assumes short sequencing and deglitch counts
`timescale 1ns/1ps
module enable_and_power_good_control_test;
  import epg_pkg::*;
  localparam int unsigned SQ = 20;
  localparam int unsigned GL = 8;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, en_req = 1'b0;
  logic        above = 1'b1, below = 1'b0, hot = 1'b0, ack, err, conn, pg_d, pg_oe, pg, enable, ok, nak;
  logic [3:0]  sel = 4'hF, bsel = 4'hF;
  logic [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat, rd, x = 32'h0000_001E;
  logic [5:0]  good = 6'h3F, on, dis, c6, d6;
  int          err_total = 0, checked = 0;
  always #2.5 clk_i = ~clk_i;
  epg_ctrl #(.SEQ_CYC(SQ), .GLITCH_CYC(GL)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .enable_i(enable), .supply_above_upper_i(above), .supply_below_lower_i(below),
    .thermal_fault_i(hot), .channel_good_i(good), .channel_on_o(on), .discharge_en_o(dis),
    .boost_disconnect_close_o(conn), .global_power_good_out_o(pg_d), .global_power_good_out_oe_o(pg_oe));
  epg_host u_host (.clk_i, .en_req_i(en_req), .pg_oe_i(pg_oe), .enable_o(enable), .pg_level_o(pg));

  function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function logic [31:0] exp_ctrl(input logic [5:0] c, input logic [5:0] d, input logic [5:0] m);
    return {10'h000, m, 2'h0, d, 2'h0, c};
  endfunction
  function logic [5:0] exp_dis(input logic [5:0] c, input logic [5:0] d);
    return ~c & d;
  endfunction
  task print_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
    ok = ack;
    nak = err;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  task wait_on(input logic [5:0] t);
    int i;
    for (i = 0; i < 400 && on !== t; i++) @(posedge clk_i);
    chk(on, t);
    if (on !== t) print_verdict();
  endtask

  initial begin
    cyc_n(6);
    rst_i <= 1'b0;
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(ok, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(nak, 32'h0000_0001);
    $display("test refused done");
    en_req <= 1'b1;
    wait_on(6'h3F);
    cyc_n(3);
    chk(pg, 32'h0000_0001);
    chk(conn, 32'h0000_0001);
    chk(pg_d, 32'h0000_0000);
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, exp_ctrl(CHEN_RST, DSEL_RST, MASK_RST));
    chk(ok, 32'h0000_0001);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test start done");
    hot <= 1'b1;
    cyc_n(int'(rnd() % 4) + 1);
    hot <= 1'b0;
    cyc_n(GL + 4);
    chk(pg, 32'h0000_0001);
    hot <= 1'b1;
    cyc_n(GL + 6);
    chk(pg, 32'h0000_0000);
    hot <= 1'b0;
    cyc_n(6);
    chk(pg, 32'h0000_0001);
    $display("test deglitch done");
    bus(1'b1, CTRL_OFS, exp_ctrl(6'h3F, DSEL_RST, 6'h04));
    good <= 6'h3B;
    cyc_n(GL + 6);
    chk(pg, 32'h0000_0001);
    good <= 6'h39;
    cyc_n(GL + 6);
    chk(pg, 32'h0000_0000);
    good <= 6'h3F;
    above <= 1'b0;
    cyc_n(10);
    chk(on, 6'h3F);
    below <= 1'b1;
    cyc_n(6);
    chk(on, 6'h00);
    below <= 1'b0;
    above <= 1'b1;
    wait_on(6'h01);
    cyc_n(SQ - 1);
    chk(on, 6'h01);
    cyc_n(1);
    chk(on, 6'h03);
    wait_on(6'h3F);
    $display("test mask and supply done");
    c6 = 6'(rnd());
    d6 = 6'(rnd());
    bus(1'b1, CTRL_OFS, exp_ctrl(c6, d6, 6'h00));
    cyc_n(2);
    chk(on, c6);
    chk(dis, exp_dis(c6, d6));
    bsel = 4'h4;
    bus(1'b1, CTRL_OFS, exp_ctrl(6'h00, 6'h00, 6'h3F));
    bsel = 4'hF;
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, exp_ctrl(c6, d6, 6'h3F));
    en_req <= 1'b0;
    cyc_n(6);
    chk(on, 6'h00);
    chk(conn, 32'h0000_0000);
    chk(dis, d6);
    bus(1'b0, STAT_OFS, 32'h0000_0000);
    chk(ok, 32'h0000_0000);
    chk(nak, 32'h0000_0001);
    $display("test shutdown done");
    print_verdict();
  end
endmodule
